// *** logic/hui_map.svh ***
// register offsets, field positions, reset values and codes of the host uart register interface
//
// Behaviour
// - standard uart host register set, switchable between fifo and non-fifo mode
// - non-fifo mode acts as a single-character buffer with no fifo features
// - location 2 read: fifos-enabled 7-6, zero 5-4, pending code 3-1, 0 when pending
// - location 2 write: trigger 7-6, dma 3, tx reset 2, rx reset 1, enable 0
// - location 5: fifo error, tx idle, holding empty, break, framing, parity, overrun, ready
// - location 6: dcd ri dsr cts levels high, low bits flag dcd dsr cts changes and a ri fall
// - location 3: divisor select, break, stick, even parity, parity on, stop, length
// - 16-byte receive and transmit fifos, active only with fifo enable set
// - divisor select clear: data and enables at 0/1; set: divisor low/high bytes
// - receive trigger codes 00 01 10 11 give 1 4 8 14 bytes
`ifndef HUI_MAP_SVH
`define HUI_MAP_SVH

`define HUI_A_DATA 3'h0
`define HUI_A_IEN 3'h1
`define HUI_A_IID 3'h2
`define HUI_A_FMT 3'h3
`define HUI_A_MCTL 3'h4
`define HUI_A_LST 3'h5
`define HUI_A_MST 3'h6
`define HUI_A_SPARE 3'h7

`define HUI_FS_EN 0
`define HUI_FS_RXRST 1
`define HUI_FS_TXRST 2
`define HUI_FS_DMA 3
`define HUI_FMT_DIV 7
`define HUI_MC_LOOP 4

`define HUI_RST_BYTE 8'h00
`define HUI_MC_MASK 8'h1F
`define HUI_IEN_MASK 8'h0F

`define HUI_ID_LINE 3'h3
`define HUI_ID_RX 3'h2
`define HUI_ID_TX_HOLDING_EMPTY 3'h1
`define HUI_ID_MODEM 3'h0

`define HUI_TRIG_L0 5'h01
`define HUI_TRIG_L1 5'h04
`define HUI_TRIG_L2 5'h08
`define HUI_TRIG_L3 5'h0E

`endif

// *** logic/hui_pkg.sv ***
// types shared by the host uart register interface
package hui_pkg;
  typedef logic [7:0] hui_byte_t;
  typedef enum logic [1:0] {HUI_TRIG_1, HUI_TRIG_4, HUI_TRIG_8, HUI_TRIG_14} hui_trig_t;
endpackage : hui_pkg

// *** logic/hui_uart.sv ***
// host uart register interface: byte fifo and register block
`timescale 1ns/1ps
`include "hui_map.svh"

// ****************************************
// byte fifo
// ****************************************
module hui_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic lim1_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [CW-1:0] cnt;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  wire [AW-1:0] next_wp = (wp == AW'(DEPTH - 1)) ? '0 : AW'(wp + 1'b1);
  wire [AW-1:0] next_rp = (rp == AW'(DEPTH - 1)) ? '0 : AW'(rp + 1'b1);

  // a one-deep limit gives the single-character holding buffer
  assign in_ready_o = lim1_i ? (cnt == '0) : (cnt != CW'(DEPTH));
  assign out_valid_o = cnt != '0;
  assign out_data_o = mem[rp];
  assign count_o = cnt;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || flush_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= next_wp;
      if (pop) rp <= next_rp;
      cnt <= CW'(cnt + CW'(push) - CW'(pop));
    end
  end

  fifo_bound_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) cnt <= CW'(DEPTH))
    else $error("fifo count beyond its limit");
  fifo_single_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    lim1_i && !flush_i && $past(lim1_i) && $past(cnt) <= 1 |-> cnt <= 1)
    else $error("single buffer holds more than one byte");
endmodule : hui_fifo

// ****************************************
// register block
// ****************************************
module hui_uart #(
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] host_addr_i,
  input wire logic host_cs_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire hui_pkg::hui_byte_t host_wdata_i,
  output hui_pkg::hui_byte_t host_rdata_o,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire hui_pkg::hui_byte_t rx_data_i,
  input wire logic rx_perr_i,
  input wire logic rx_ferr_i,
  input wire logic rx_brk_i,
  input wire logic rx_overrun_i,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output hui_pkg::hui_byte_t tx_data_o,
  input wire logic tx_busy_i,
  input wire logic dcd_i,
  input wire logic ri_i,
  input wire logic dsr_i,
  input wire logic cts_i,
  output logic dtr_o,
  output logic rts_o,
  output logic out1_o,
  output logic out2_o,
  output logic loop_o,
  output hui_pkg::hui_byte_t format_o,
  output logic [15:0] divisor_o,
  output logic rxrdy_o,
  output logic txrdy_o
);
  import hui_pkg::*;
  localparam int CW = $clog2(DEPTH) + 1;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] loc);
    return a == loc;
  endfunction : hit

  function automatic logic [4:0] trig_level(input hui_trig_t t);
    unique case (t)
      HUI_TRIG_1: return `HUI_TRIG_L0;
      HUI_TRIG_4: return `HUI_TRIG_L1;
      HUI_TRIG_8: return `HUI_TRIG_L2;
      HUI_TRIG_14: return `HUI_TRIG_L3;
    endcase
  endfunction : trig_level

  // ****************************************
  // registers and access decode
  // ****************************************
  hui_byte_t fmt, mctl, spare, ien, div_lo, div_hi;
  logic fen, dma;
  hui_trig_t trig;
  logic oe, err_ack, tx_holding_empty_ack;
  logic [3:0] lv_q, delta;
  logic [CW-1:0] err_cnt;
  hui_byte_t rdata;

  wire acc_wr = host_cs_i & host_wr_i;
  wire acc_rd = host_cs_i & host_rd_i;
  wire divisor_access_select = fmt[`HUI_FMT_DIV];
  wire wr_thr = acc_wr & hit(host_addr_i, `HUI_A_DATA) & !divisor_access_select;
  wire wr_dll = acc_wr & hit(host_addr_i, `HUI_A_DATA) & divisor_access_select;
  wire wr_ien = acc_wr & hit(host_addr_i, `HUI_A_IEN) & !divisor_access_select;
  wire wr_dlm = acc_wr & hit(host_addr_i, `HUI_A_IEN) & divisor_access_select;
  wire wr_fs = acc_wr & hit(host_addr_i, `HUI_A_IID);
  wire wr_fmt = acc_wr & hit(host_addr_i, `HUI_A_FMT);
  wire wr_mctl = acc_wr & hit(host_addr_i, `HUI_A_MCTL);
  wire wr_spare = acc_wr & hit(host_addr_i, `HUI_A_SPARE);
  wire rd_rbr = acc_rd & hit(host_addr_i, `HUI_A_DATA) & !divisor_access_select;
  wire rd_iid = acc_rd & hit(host_addr_i, `HUI_A_IID);
  wire rd_lst = acc_rd & hit(host_addr_i, `HUI_A_LST);
  wire rd_mst = acc_rd & hit(host_addr_i, `HUI_A_MST);

  // changing the enable flushes both fifos, so no byte crosses a mode switch
  wire fen_chg = wr_fs & (host_wdata_i[`HUI_FS_EN] != fen);
  wire rx_flush = wr_fs & (host_wdata_i[`HUI_FS_RXRST] | fen_chg);
  wire tx_flush = wr_fs & (host_wdata_i[`HUI_FS_TXRST] | fen_chg);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fmt <= `HUI_RST_BYTE;
      mctl <= `HUI_RST_BYTE;
      spare <= `HUI_RST_BYTE;
      ien <= `HUI_RST_BYTE;
      div_lo <= `HUI_RST_BYTE;
      div_hi <= `HUI_RST_BYTE;
      fen <= 1'b0;
      dma <= 1'b0;
      trig <= HUI_TRIG_1;
    end else begin
      if (wr_fmt) fmt <= host_wdata_i;
      if (wr_mctl) mctl <= host_wdata_i & `HUI_MC_MASK;
      if (wr_spare) spare <= host_wdata_i;
      if (wr_ien) ien <= host_wdata_i & `HUI_IEN_MASK;
      if (wr_dll) div_lo <= host_wdata_i;
      if (wr_dlm) div_hi <= host_wdata_i;
      if (wr_fs) begin
        fen <= host_wdata_i[`HUI_FS_EN];
        dma <= host_wdata_i[`HUI_FS_DMA];
        trig <= hui_trig_t'(host_wdata_i[7:6]);
      end
    end
  end

  // ****************************************
  // receive and transmit paths
  // ****************************************
  logic rx_vld, tx_rdy;
  logic [10:0] rx_head;
  logic [CW-1:0] rx_cnt, tx_cnt;
  wire rx_pop = rd_rbr & rx_vld;
  wire rx_push = rx_valid_i & rx_ready_o;
  wire push_err = rx_push & (rx_perr_i | rx_ferr_i | rx_brk_i);
  wire pop_err = rx_pop & (|rx_head[10:8]);

  hui_fifo #(.WIDTH(11), .DEPTH(DEPTH)) u_rx_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .flush_i(rx_flush),
    .lim1_i(!fen),
    .in_valid_i(rx_valid_i),
    .in_ready_o(rx_ready_o),
    .in_data_i({rx_brk_i, rx_ferr_i, rx_perr_i, rx_data_i}),
    .out_valid_o(rx_vld),
    .out_ready_i(rd_rbr),
    .out_data_o(rx_head),
    .count_o(rx_cnt)
  );

  // host writes into a full holding buffer are dropped; txrdy_o warns ahead of it
  hui_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .flush_i(tx_flush),
    .lim1_i(!fen),
    .in_valid_i(wr_thr),
    .in_ready_o(tx_rdy),
    .in_data_i(host_wdata_i),
    .out_valid_o(tx_valid_o),
    .out_ready_i(tx_ready_i),
    .out_data_o(tx_data_o),
    .count_o(tx_cnt)
  );

  // ****************************************
  // line status
  // ****************************************
  wire [2:0] head_err = (rx_vld && !err_ack) ? rx_head[10:8] : 3'h0;
  wire tx_holding_empty = tx_cnt == '0;
  wire transmitter_idle = tx_holding_empty & !tx_busy_i;
  wire fifo_err = fen & (err_cnt != '0);
  wire [7:0] lst = {fifo_err, transmitter_idle, tx_holding_empty, head_err, oe, rx_vld};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || rx_flush) begin
      err_cnt <= '0;
      err_ack <= 1'b0;
    end else begin
      err_cnt <= CW'(err_cnt + CW'(push_err) - CW'(pop_err));
      // a pop brings a new head whose flags must show, so it beats the read
      err_ack <= rx_pop ? 1'b0 : (err_ack | rd_lst);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      oe <= 1'b0;
    end else begin
      oe <= rx_overrun_i | (oe & !rd_lst);
    end
  end

  // ****************************************
  // modem signals
  // ****************************************
  wire loop = mctl[`HUI_MC_LOOP];
  wire [3:0] lv = loop ? {mctl[3], mctl[2], mctl[0], mctl[1]} : {dcd_i, ri_i, dsr_i, cts_i};
  wire [3:0] chg = lv ^ lv_q;
  wire [3:0] msr_new = {chg[3], lv_q[2] & !lv[2], chg[1], chg[0]};
  wire [7:0] mst = {lv, delta};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lv_q <= 4'h0;
      delta <= 4'h0;
    end else begin
      lv_q <= lv;
      delta <= (delta & ~{4{rd_mst}}) | msr_new;
    end
  end

  assign dtr_o = mctl[0] & !loop;
  assign rts_o = mctl[1] & !loop;
  assign out1_o = mctl[2] & !loop;
  assign out2_o = mctl[3] & !loop;
  assign loop_o = loop;

  // ****************************************
  // interrupt identification
  // ****************************************
  wire rx_hit = rx_cnt >= CW'(trig_level(trig));
  wire pend_line = ien[2] & (oe | (|head_err));
  wire pend_rx = ien[0] & (fen ? rx_hit : rx_vld);
  wire pend_tx_holding_empty = ien[1] & tx_holding_empty & !tx_holding_empty_ack;
  wire pend_ms = ien[3] & (|delta);
  wire pend = pend_line | pend_rx | pend_tx_holding_empty | pend_ms;
  wire [2:0] iid = pend_line ? `HUI_ID_LINE : pend_rx ? `HUI_ID_RX : pend_tx_holding_empty ? `HUI_ID_TX_HOLDING_EMPTY : `HUI_ID_MODEM;
  wire [7:0] interrupt_source_id = {fen, fen, 2'b00, iid, !pend};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_holding_empty_ack <= 1'b0;
    end else if (wr_thr) begin
      tx_holding_empty_ack <= 1'b0;
    end else if (rd_iid && pend && iid == `HUI_ID_TX_HOLDING_EMPTY) begin
      tx_holding_empty_ack <= 1'b1;
    end
  end

  // ****************************************
  // read data and side outputs
  // ****************************************
  wire [7:0] rd_data0 = divisor_access_select ? div_lo : (rx_vld ? rx_head[7:0] : 8'h00);
  wire [7:0] rd_data1 = divisor_access_select ? div_hi : ien;
  wire [7:0] rd_mux =
    hit(host_addr_i, `HUI_A_DATA) ? rd_data0 :
    hit(host_addr_i, `HUI_A_IEN) ? rd_data1 :
    hit(host_addr_i, `HUI_A_IID) ? interrupt_source_id :
    hit(host_addr_i, `HUI_A_FMT) ? fmt :
    hit(host_addr_i, `HUI_A_MCTL) ? mctl :
    hit(host_addr_i, `HUI_A_LST) ? lst :
    hit(host_addr_i, `HUI_A_MST) ? mst : spare;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata <= `HUI_RST_BYTE;
    end else if (acc_rd) begin
      rdata <= rd_mux;
    end
  end

  // dma is meaningless without fifos, so it only counts while they are on
  wire dma_on = fen & dma;
  assign rxrdy_o = dma_on ? rx_hit : rx_vld;
  assign txrdy_o = dma_on ? tx_rdy : tx_holding_empty;
  assign host_rdata_o = rdata;
  assign format_o = fmt;
  assign divisor_o = {div_hi, div_lo};

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_change;
    !loop && $changed(cts_i) && !rd_mst;
  endsequence
  sequence s_read_mst;
    rd_mst && msr_new == 4'h0;
  endsequence

  iir_layout_a: assert property (host_rdata_o[5:4] == 2'b00 || !$past(rd_iid) || $past(rst_i))
    else $error("id register bits 5-4 not zero");
  iir_fifo_a: assert property (rd_iid |=> host_rdata_o[7:6] == {2{$past(fen)}} && host_rdata_o[0] == !$past(pend))
    else $error("id register fifo or pending bit wrong");
  rx_flush_a: assert property (wr_fs && host_wdata_i[`HUI_FS_RXRST] |=> rx_cnt == '0 && !lst[0] && err_cnt == '0)
    else $error("receive reset did not empty the fifo");
  data_ready_a: assert property ((rx_push && !rx_flush |=> lst[0]) and lst[0] == (rx_cnt != '0))
    else $error("data ready disagrees with receive fill");
  cts_delta_a: assert property (s_change |=> delta[0] ##0 mst[4] == $past(cts_i))
    else $error("clear to send change not caught");
  mst_clear_a: assert property (s_read_mst |=> delta == 4'h0)
    else $error("modem status read did not clear changes");
  fmt_store_a: assert property (wr_fmt |=> format_o == $past(host_wdata_i))
    else $error("format register not stored");
  div_low_a: assert property (wr_dll |=> divisor_o[7:0] == $past(host_wdata_i) && ien == $past(ien))
    else $error("divisor low write went astray");
  trig_rx_a: assert property (fen && ien[0] && !pend_line && rx_cnt >= CW'(trig_level(trig)) |-> iid == `HUI_ID_RX)
    else $error("receive trigger did not raise its code");
  nonfifo_a: assert property (!fen && !$past(fen) |-> rx_cnt <= 1 && tx_cnt <= 1 && !dma_on)
    else $error("fifo behaviour active in non-fifo mode");
  mctl_top_a: assert property (wr_mctl |=> mctl[7:5] == 3'h0 && mctl[4:0] == $past(host_wdata_i[4:0]))
    else $error("modem control upper bits not zero");
endmodule : hui_uart

// *** tb/hui_line_model.sv ***
// line side model: offers received bytes and takes transmitted ones
`timescale 1ns/1ps

// ****************************************
// receive source and transmit sink
// ****************************************
module hui_line_model (
  input wire logic ref_clk_i,
  input wire logic rx_ready_i,
  input wire logic tx_valid_i,
  input wire hui_pkg::hui_byte_t tx_data_i,
  input wire logic stall_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output hui_pkg::hui_byte_t rx_data_o,
  output logic [2:0] rx_flags_o
);
  import hui_pkg::*;
  logic [10:0] q[$];
  hui_byte_t got[$];
  logic took = 1'b0;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'hA5;
    rx_flags_o = 3'h0;
  end
  assign tx_ready_o = !stall_i;
  always @(posedge ref_clk_i) begin
    took = rx_valid_o && rx_ready_i;
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
    end
  end
  // byte and flags held until taken; idle data toggles so a stale value never matches
  always @(negedge ref_clk_i) begin
    if (took) begin
      void'(q.pop_front());
      took = 1'b0;
    end
    rx_valid_o <= q.size() != 0;
    if (q.size() != 0) begin
      {rx_flags_o, rx_data_o} <= q[0];
    end else begin
      rx_data_o <= ~rx_data_o;
    end
  end
endmodule : hui_line_model

// *** tb/test_hui_uart.sv ***
// self-checking bench for the host uart register interface
`timescale 1ns/1ps
module test_hui_uart;
  import hui_pkg::*;
  logic ref_clk_i = 0, rst_i = 1, host_cs_i = 0, host_rd_i = 0, host_wr_i = 0;
  logic stall = 1, tx_busy_i = 0, rx_overrun_i = 0;
  logic [2:0] host_addr_i = 3'h0;
  logic [3:0] mi = 4'h0;
  hui_byte_t host_wdata_i = 8'h00, host_rdata_o, rx_data_i, tx_data_o, format_o;
  logic rx_valid_i, rx_ready_o, rx_perr_i, rx_ferr_i, rx_brk_i, tx_valid_o, tx_ready_i;
  logic dcd_i, ri_i, dsr_i, cts_i, dtr_o, rts_o, out1_o, out2_o, loop_o, rxrdy_o, txrdy_o;
  logic [15:0] divisor_o;
  int n_mismatch = 0, checks = 0;
  int lv[4] = '{1, 4, 8, 14};
  hui_byte_t rv[8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00};
  assign {dcd_i, ri_i, dsr_i, cts_i} = mi;
  always #12.5 ref_clk_i = ~ref_clk_i;
  hui_uart hui_uart_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .host_addr_i(host_addr_i),
    .host_cs_i(host_cs_i),
    .host_rd_i(host_rd_i),
    .host_wr_i(host_wr_i),
    .host_wdata_i(host_wdata_i),
    .host_rdata_o(host_rdata_o),
    .rx_valid_i(rx_valid_i),
    .rx_ready_o(rx_ready_o),
    .rx_data_i(rx_data_i),
    .rx_perr_i(rx_perr_i),
    .rx_ferr_i(rx_ferr_i),
    .rx_brk_i(rx_brk_i),
    .rx_overrun_i(rx_overrun_i),
    .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i),
    .tx_data_o(tx_data_o),
    .tx_busy_i(tx_busy_i),
    .dcd_i(dcd_i),
    .ri_i(ri_i),
    .dsr_i(dsr_i),
    .cts_i(cts_i),
    .dtr_o(dtr_o),
    .rts_o(rts_o),
    .out1_o(out1_o),
    .out2_o(out2_o),
    .loop_o(loop_o),
    .format_o(format_o),
    .divisor_o(divisor_o),
    .rxrdy_o(rxrdy_o),
    .txrdy_o(txrdy_o)
  );
  hui_line_model hui_line_model_i (.ref_clk_i(ref_clk_i), .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .stall_i(stall), .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .rx_flags_o({rx_brk_i, rx_ferr_i, rx_perr_i}));

  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : tick
  // strobe held for exactly one edge: a longer read would pop twice
  task automatic wr(logic [2:0] a, hui_byte_t d);
    @(negedge ref_clk_i);
    {host_cs_i, host_wr_i, host_addr_i, host_wdata_i} = {2'b11, a, d};
    @(negedge ref_clk_i);
    {host_cs_i, host_wr_i} = 2'b00;
  endtask : wr
  task automatic rd(logic [2:0] a, hui_byte_t exp);
    @(negedge ref_clk_i);
    {host_cs_i, host_rd_i, host_addr_i} = {2'b11, a};
    @(negedge ref_clk_i);
    {host_cs_i, host_rd_i} = 2'b00;
    chk($sformatf("location %0d", a), host_rdata_o, exp);
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial begin
    #100us;
    n_mismatch++;
    print_verdict();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i) rst_i = 0;
    foreach (rv[i]) rd(i[2:0], rv[i]);
    chk("txrdy", txrdy_o, 1);
    wr(7, 8'h5A);
    rd(7, 8'h5A);
    wr(4, 8'hEF);
    rd(4, 8'h0F);
    chk("pins", {loop_o, out2_o, out1_o, rts_o, dtr_o}, 5'h0F);
    mi = 4'hA;
    tick(3);
    rd(6, 8'hAA);
    rd(6, 8'hA0);
    mi = 4'h0;
    tick(3);
    rd(6, 8'h0A);
    wr(4, 8'h1F);
    chk("loop pins", {loop_o, out2_o, out1_o, rts_o, dtr_o}, 5'h10);
    tick(3);
    rd(6, 8'hFB);
    wr(4, 8'h00);
    tick(3);
    rd(6, 8'h0F);
    mi = 4'h1;
    tick(3);
    rd(6, 8'h11);
    mi = 4'h0;
    tick(3);
    rd(6, 8'h01);
    wr(3, 8'h83);
    chk("format", format_o, 8'h83);
    wr(0, 8'h34);
    wr(1, 8'h12);
    chk("divisor", divisor_o, 16'h1234);
    rd(0, 8'h34);
    rd(1, 8'h12);
    wr(3, 8'h7C);
    rd(3, 8'h7C);
    wr(1, 8'hFF);
    rd(1, 8'h0F);
    rd(2, 8'h02);
    rd(2, 8'h01);
    wr(0, 8'hC3);
    wr(0, 8'h3C);
    chk("tx head", tx_data_o, 8'hC3);
    rd(5, 8'h00);
    stall = 0;
    tick(3);
    chk("tx count", hui_line_model_i.got.size(), 1);
    tx_busy_i = 1;
    rd(5, 8'h20);
    tx_busy_i = 0;
    hui_line_model_i.q.push_back(11'h011);
    hui_line_model_i.q.push_back(11'h122);
    tick(4);
    chk("rx ready", rx_ready_o, 0);
    rd(5, 8'h61);
    rd(0, 8'h11);
    tick(3);
    rd(2, 8'h06);
    rd(5, 8'h65);
    rd(5, 8'h61);
    rd(0, 8'h22);
    rx_overrun_i = 1;
    tick(1);
    rx_overrun_i = 0;
    rd(5, 8'h62);
    rd(5, 8'h60);
    wr(1, 8'h01);
    wr(2, 8'h01);
    rd(2, 8'hC1);
    for (int i = 0; i < 17; i++) hui_line_model_i.q.push_back(11'(i));
    tick(20);
    chk("rx full", rx_ready_o, 0);
    rd(2, 8'hC4);
    for (int i = 0; i < 17; i++) rd(0, i[7:0]);
    hui_line_model_i.q.push_back(11'h2C3);
    tick(4);
    rd(5, 8'hE9);
    rd(5, 8'hE1);
    for (int c = 0; c < 4; c++) begin
      wr(2, {c[1:0], 6'h0B});
      repeat (lv[c] - 1) hui_line_model_i.q.push_back(11'h0AA);
      tick(20);
      chk("rxrdy low", rxrdy_o, 0);
      hui_line_model_i.q.push_back(11'h0AA);
      tick(4);
      chk("rxrdy high", rxrdy_o, 1);
    end
    wr(2, 8'h0B);
    stall = 1;
    for (int i = 0; i < 17; i++) wr(0, 8'h40 + i[7:0]);
    chk("txrdy full", txrdy_o, 0);
    stall = 0;
    tick(20);
    chk("tx total", hui_line_model_i.got.size(), 17);
    chk("tx last", hui_line_model_i.got[16], 8'h4F);
    stall = 1;
    wr(0, 8'h77);
    wr(2, 8'h0D);
    chk("tx flushed", tx_valid_o, 0);
    stall = 0;
    wr(2, 8'h00);
    rd(2, 8'h01);
    print_verdict();
  end
endmodule : test_hui_uart
